// >>> rtl/dsc_code_map.sv
/*
  Holds the shared constants of the sample capture block and the code mapper
  that turns a captured sample word into the two complementary current codes.
  Assumes a single clock domain and a sample width of 8, 10, 12 or 14 bits.
*/
`timescale 1ns/1ps
`default_nettype none

package dsc_pkg;
  localparam int SAMPLE_BITS_DEFAULT = 14;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MAX_RATE_MSPS = 175;
  localparam int MIN_SAMPLE_PERIOD_PS = 1000000 / MAX_RATE_MSPS;
  localparam int MIN_SAMPLE_CYCLES_RAW =
    (MIN_SAMPLE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MIN_SAMPLE_CYCLES = (MIN_SAMPLE_CYCLES_RAW < 1) ? 1 : MIN_SAMPLE_CYCLES_RAW;
  localparam logic [7:0] IDX_DATA_CFG = 8'h02;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam int BIT_CODING = 7;
  localparam int BIT_POLARITY = 4;
  localparam int BIT_DESKEW = 3;
  localparam int BIT_DIFF_CLK = 2;
  localparam logic [7:0] DATA_CFG_MASK = 8'h9C;
  localparam logic [7:0] DATA_CFG_RESET = 8'h00;
  localparam int STAT_BIT_DIFF = 0;
  localparam int STAT_BIT_SERIAL = 1;
  localparam int STAT_BIT_STRAP = 2;
  localparam int STAT_CODE_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dsc_pkg

module dsc_code_map #(
  parameter int SAMPLE_BITS = dsc_pkg::SAMPLE_BITS_DEFAULT
) (
  input wire logic [SAMPLE_BITS-1:0] sample_word,
  input wire logic twos_complement,
  output logic [SAMPLE_BITS-1:0] primary_code,
  output logic [SAMPLE_BITS-1:0] complementary_code
);
  always_comb begin
    primary_code = sample_word;
    primary_code[SAMPLE_BITS-1] = sample_word[SAMPLE_BITS-1] ^ twos_complement;
    complementary_code = ~primary_code;
  end
endmodule : dsc_code_map

`default_nettype wire

// >>> rtl/dsc_capture.sv
/*
  Sample input capture of a current-output converter, with its configuration
  registers on an AXI4-Lite slave. Assumes all inputs are synchronous to clk,
  one clk edge per sample, and a source that holds its data stable around the edge.
*/
// The address map and the AXI4-Lite register port were chosen for this implementation.
// Summary of operation
// - Accept N-bit sample word with sample clock.
// - Decode straight binary or twos complement samples.
// - All-ones code in straight binary: full primary, zero complementary.
// - Primary is code, complementary its remainder.
// - Edge-triggered capture; output updates every rising edge.
// - Capture path runs up to 175 MSPS.
// - Deskew adds exactly one cycle of latency.
// - Deskew bit lives in register 0x02, resets 0.
// - Clock mode from strap or register bit 2.
// - Strap low or bit 0: single-ended clock.
// - Strap high or bit 1: differential clock.
// - Bit 7 selects coding, reset binary.
// - Bit 3 enables the deskew register stage.
// - Bit 4 selects falling capture, deskew only.
`timescale 1ns/1ps
`default_nettype none

module dsc_capture #(
  parameter int SAMPLE_BITS = dsc_pkg::SAMPLE_BITS_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [SAMPLE_BITS-1:0] sample_data,
  input wire logic serial_mode_enable,
  input wire logic clock_mode_strap,
  output logic [SAMPLE_BITS-1:0] primary_current_output,
  output logic [SAMPLE_BITS-1:0] complementary_current_output,
  output logic differential_clock_select,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] data_cfg_r;
  logic strap_r;
  logic strap_pending_r;
  logic [SAMPLE_BITS-1:0] rise_stage_r;
  logic [SAMPLE_BITS-1:0] fall_stage_r;
  logic [SAMPLE_BITS-1:0] deskew_stage_r;
  logic [SAMPLE_BITS-1:0] conv_in;
  logic [SAMPLE_BITS-1:0] primary_nxt;
  logic [SAMPLE_BITS-1:0] complementary_nxt;
  logic deskew_on;
  logic falling_capture;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] rd_data_nxt;
  logic rd_hit;
  logic [31:0] status_word;

  assign deskew_on = data_cfg_r[dsc_pkg::BIT_DESKEW];
  assign falling_capture = deskew_on & data_cfg_r[dsc_pkg::BIT_POLARITY];

  // The strap level is caught on the first edge after reset is released.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      strap_r <= 1'b0;
      strap_pending_r <= 1'b1;
    end else if (strap_pending_r) begin
      strap_r <= clock_mode_strap;
      strap_pending_r <= 1'b0;
    end
  end

  // Clock mode follows the strap in pin mode and the register bit otherwise.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      differential_clock_select <= 1'b0;
    end else if (serial_mode_enable) begin
      differential_clock_select <= data_cfg_r[dsc_pkg::BIT_DIFF_CLK];
    end else begin
      differential_clock_select <= strap_r;
    end
  end

  // Rising-edge capture of the sample word; one word per clock edge.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rise_stage_r <= '0;
    end else begin
      rise_stage_r <= sample_data;
    end
  end

  // Falling-edge capture, used only when deskew is on and polarity asks for it.
  always_ff @(negedge clk) begin
    if (!resetn) begin
      fall_stage_r <= '0;
    end else begin
      fall_stage_r <= sample_data;
    end
  end

  // The deskew register adds one cycle between capture and conversion.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      deskew_stage_r <= '0;
    end else if (falling_capture) begin
      deskew_stage_r <= fall_stage_r;
    end else begin
      deskew_stage_r <= rise_stage_r;
    end
  end

  assign conv_in = deskew_on ? deskew_stage_r : rise_stage_r;

  dsc_code_map #(
    .SAMPLE_BITS(SAMPLE_BITS)
  ) u_code_map (
    .sample_word(conv_in),
    .twos_complement(data_cfg_r[dsc_pkg::BIT_CODING]),
    .primary_code(primary_nxt),
    .complementary_code(complementary_nxt)
  );

  // The primary current code updates on every rising edge.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      primary_current_output <= '0;
    end else begin
      primary_current_output <= primary_nxt;
    end
  end

  // The complementary code updates on the same edge, so the pair never splits.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      complementary_current_output <= '1;
    end else begin
      complementary_current_output <= complementary_nxt;
    end
  end

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  assign wr_fire = (aw_held_r | aw_take) & (w_held_r | w_take) & ~s_axi_bvalid;
  assign wr_hit = (wr_addr[7:2] == dsc_pkg::IDX_DATA_CFG[5:0]);

  // The write address is held until its data has arrived as well.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
  end

  // The write data and strobes are held until their address has arrived as well.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
  end

  // Address ready is low while an address is held or a response is pending.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~(aw_held_r | aw_take | wr_fire | s_axi_bvalid);
    end
  end

  // Data ready is low while data is held or a response is pending.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~(w_held_r | w_take | wr_fire | s_axi_bvalid);
    end
  end

  // The response is raised once both halves are in and stands until it is taken.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Unmapped addresses answer with an error and change nothing.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_bresp <= dsc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bresp <= wr_hit ? dsc_pkg::RESP_OKAY : dsc_pkg::RESP_SLVERR;
    end
  end

  // The data configuration register comes out of reset all zero.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      data_cfg_r <= dsc_pkg::DATA_CFG_RESET;
    end else if (wr_fire && wr_hit && wr_strb[0]) begin
      data_cfg_r <= wr_data[7:0] & dsc_pkg::DATA_CFG_MASK;
    end
  end

  // Status word: clock mode, serial mode, captured strap and the current code.
  always_comb begin
    status_word = 32'h00000000;
    status_word[dsc_pkg::STAT_BIT_DIFF] = differential_clock_select;
    status_word[dsc_pkg::STAT_BIT_SERIAL] = serial_mode_enable;
    status_word[dsc_pkg::STAT_BIT_STRAP] = strap_r;
    status_word[dsc_pkg::STAT_CODE_LSB +: SAMPLE_BITS] = primary_current_output;
  end

  // Only the configuration and status words are mapped.
  assign rd_hit = (s_axi_araddr[7:2] == dsc_pkg::IDX_DATA_CFG[5:0]) ||
                  (s_axi_araddr[7:2] == dsc_pkg::IDX_STATUS[5:0]);

  // Read data is chosen by the read address; unmapped words read zero.
  always_comb begin
    rd_data_nxt = 32'h00000000;
    if (s_axi_araddr[7:2] == dsc_pkg::IDX_DATA_CFG[5:0]) begin
      rd_data_nxt[7:0] = data_cfg_r;
    end else if (s_axi_araddr[7:2] == dsc_pkg::IDX_STATUS[5:0]) begin
      rd_data_nxt = status_word;
    end
  end

  // One read at a time: address ready is low from address to data handshake.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (!s_axi_rvalid || s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Read valid rises after the address handshake and falls with the data handshake.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Read data and response are loaded with the address and stand until taken.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= dsc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= rd_data_nxt;
      s_axi_rresp <= rd_hit ? dsc_pkg::RESP_OKAY : dsc_pkg::RESP_SLVERR;
    end
  end
endmodule : dsc_capture

`default_nettype wire

// >>> verification/dsc_capture_props.sv
/* Port checker of the capture block. Assumes one clock and a bind to dsc_capture. */
`timescale 1ns/1ps
`default_nettype none
module dsc_capture_props #(
  parameter int SAMPLE_BITS = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic serial_mode_enable,
  input wire logic clock_mode_strap,
  input wire logic [SAMPLE_BITS-1:0] primary_current_output,
  input wire logic [SAMPLE_BITS-1:0] complementary_current_output,
  input wire logic differential_clock_select,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  reset_vals_a: assert property (disable iff (1'h0) !resetn |=>
    primary_current_output == '0 && !differential_clock_select && !s_axi_bvalid)
    else $error("reset values");
  comp_inv_a: assert property (
    complementary_current_output == ~primary_current_output) else $error("complement");
  diff_pin_a: assert property (!serial_mode_enable && !$past(serial_mode_enable) &&
    $past(resetn) && $past(resetn, 2) |-> differential_clock_select == clock_mode_strap)
    else $error("strap mode");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  rd_lat_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("awready");
endmodule : dsc_capture_props
bind dsc_capture dsc_capture_props #(
  .SAMPLE_BITS(SAMPLE_BITS)
) u_props (
  .clk(clk),
  .resetn(resetn),
  .serial_mode_enable(serial_mode_enable),
  .clock_mode_strap(clock_mode_strap),
  .primary_current_output(primary_current_output),
  .complementary_current_output(complementary_current_output),
  .differential_clock_select(differential_clock_select),
  .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_rdata(s_axi_rdata)
);
`default_nettype wire

// >>> verification/dsc_source_model.sv
/* Sample source model. Assumes the bench hands it each next word. */
`timescale 1ns/1ps
`default_nettype none
module dsc_source_model #(parameter int W = 8) (
  input wire logic clk,
  input wire logic [W-1:0] next_word,
  output logic [W-1:0] sample_data
);
  initial sample_data = '0;
  // Data moves on the falling edge, away from the capture edge.
  always @(negedge clk) sample_data <= next_word;
endmodule : dsc_source_model
`default_nettype wire

// >>> verification/testbench.sv
/* Self-checking bench of dsc_capture. Assumes the source model and the checker. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SB = 8;
  logic clk = 1'h0, resetn = 1'h0, serial_mode_enable = 1'h0, clock_mode_strap = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic differential_clock_select;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [SB-1:0] sample_data, next_word = 8'h00;
  logic [SB-1:0] primary_current_output, complementary_current_output;
  int n_fail = 0, n_compared = 0, cyc = 0;
  dsc_capture #(.SAMPLE_BITS(SB)) uut (.*);
  dsc_source_model #(.W(SB)) src (.*);
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    s_axi_bready <= 1'h1;
    @(posedge clk);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    s_axi_rready <= 1'h1;
    @(posedge clk);
    s_axi_rready <= 1'h0;
  endtask : rd
  // Sets the configuration, steps the word and counts edges until it shows.
  task automatic lat(input logic [7:0] c, w, input int en);
    int n;
    logic [7:0] e;
    wr(8'h08, {24'h0, c}, 2'h0);
    e = w ^ {c[7], 7'h00};
    next_word <= ~w;
    repeat (4) @(posedge clk);
    next_word <= w;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (primary_current_output !== e && n < 8);
    chk("latency", 32'(en), 32'(n));
    chk("complement", {24'h0, ~e}, {24'h0, complementary_current_output});
  endtask : lat
  task automatic t_regs();
    rd(8'h08, 32'h0, 2'h0);
    wr(8'h08, 32'hFF, 2'h0);
    rd(8'h08, 32'h9C, 2'h0);
    wr(8'h10, 32'h1, 2'h2);
    rd(8'h10, 32'h0, 2'h2);
    wr(8'h0C, 32'h1, 2'h2);
  endtask : t_regs
  task automatic t_path();
    lat(8'h00, 8'h5A, 2);
    lat(8'h00, 8'hFF, 2);
    lat(8'h10, 8'hA5, 2);
    lat(8'h08, 8'h3C, 3);
    lat(8'h18, 8'hC3, 3);
    lat(8'h80, 8'h7F, 2);
    lat(8'h88, 8'h01, 3);
  endtask : t_path
  task automatic t_clk();
    @(posedge clk);
    serial_mode_enable <= 1'h1;
    wr(8'h08, 32'h04, 2'h0);
    @(posedge clk);
    #1 chk("diff", 32'h1, 32'(differential_clock_select));
    wr(8'h08, 32'h00, 2'h0);
    @(posedge clk);
    #1 chk("diff", 32'h0, 32'(differential_clock_select));
    wr(8'h08, 32'h04, 2'h0);
    serial_mode_enable <= 1'h0;
    repeat (2) @(posedge clk);
    #1 chk("strap", 32'h0, 32'(differential_clock_select));
    @(posedge clk);
    resetn <= 1'h0;
    clock_mode_strap <= 1'h1;
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    repeat (3) @(posedge clk);
    #1 chk("strap", 32'h1, 32'(differential_clock_select));
    rd(8'h08, 32'h0, 2'h0);
    rd(8'h0C, 32'h00010005, 2'h0);
  endtask : t_clk
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    t_regs();
    t_path();
    t_clk();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
